// >>> inc/cdz_consts.svh
`ifndef CDZ_CONSTS_SVH
`define CDZ_CONSTS_SVH
`define CDZ_ZD_OFF 2'h0
`define CDZ_ZD_INTERNAL 2'h1
`define CDZ_ZD_EXTERNAL 2'h3
`define CDZ_SRC_EXT_PRE 2'h0
`define CDZ_SRC_EXT_BYP 2'h1
`define CDZ_SRC_OSC_PRE 2'h2
`define CDZ_SRC_FORBID 2'h3
`define CDZ_CNT_W 4
`define CDZ_PRE_MIN 3'h1
`define CDZ_PRE_MAX 3'h6
`define CDZ_ONE4 4'h1
`define CDZ_ONE3 3'h1
`define CDZ_ZERO4 4'h0
`define CDZ_ZERO3 3'h0
`define CDZ_NCH 4
`endif

// >>> inc/cdz_pkg.sv
`include "cdz_consts.svh"
package cdz_pkg;
    typedef enum logic [1:0] {
        CDZ_PH_RUN = 2'b00,
        CDZ_PH_HOLD = 2'b01,
        CDZ_PH_DELAY = 2'b10
    } cdz_phase_t;
endpackage : cdz_pkg

// >>> verilog/cdz_clock_distribution.sv
`timescale 1ns/1ps
`include "cdz_consts.svh"
module cdz_clock_distribution
    import cdz_pkg::*;
#(
    parameter int NCH = `CDZ_NCH
) (
    input wire logic ref_clk, // divider input clock
    input wire logic resetn, // async reset, low active
    input wire logic osc_clk_en, // oscillator source pulse (one per osc cycle)
    input wire logic ext_clk_en, // external clock input pulse
    input wire logic ext_clk_lvl, // external clock input level (feedback)
    input wire logic sync_req, // hold all dividers while high
    input wire logic [1:0] zd_mode, // zero-delay mode field
    input wire logic [1:0] fb_div_sel, // feedback divider select
    input wire logic [1:0] src_sel, // divider source field
    input wire logic [2:0] pre_ratio, // pre-divider ratio 1..6
    input wire logic [NCH*4-1:0] low_cnt, // per-channel low count m
    input wire logic [NCH*4-1:0] high_cnt, // per-channel high count n
    input wire logic [NCH-1:0] div_bypass, // per-channel divider bypass
    input wire logic [NCH-1:0] dcc_disable, // per-channel correction off
    input wire logic [NCH*4-1:0] phase_dly, // per-channel coarse delay
    input wire logic [NCH-1:0] start_high, // per-channel start level
    input wire logic [NCH-1:0] direct_route, // per-group direct route
    output logic [NCH-1:0] clock_output_pins, // channel clock to output groups
    output logic loop_feedback_mux, // feedback to loop divider
    output logic src_illegal // forbidden source or setting
);
    // ==========================================================
    // source selection and pre-divider
    logic src_pulse;
    logic [2:0] pre_cnt_ff;
    logic pre_lvl_ff;
    logic pre_tick_ff;
    logic [2:0] pre_eff;
    logic [NCH-1:0] ch_lvl;

    assign src_pulse = (src_sel == `CDZ_SRC_OSC_PRE) ? osc_clk_en : ext_clk_en;
    assign pre_eff = (pre_ratio < `CDZ_PRE_MIN) ? `CDZ_PRE_MIN :
                     (pre_ratio > `CDZ_PRE_MAX) ? `CDZ_PRE_MAX : pre_ratio;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pre_cnt_ff <= `CDZ_ZERO3;
            pre_tick_ff <= 1'b0;
            pre_lvl_ff <= 1'b0;
        end else if (sync_req) begin
            pre_cnt_ff <= `CDZ_ZERO3;
            pre_tick_ff <= 1'b0;
            pre_lvl_ff <= 1'b0;
        end else begin
            pre_tick_ff <= 1'b0;
            if (src_pulse) begin
                pre_lvl_ff <= ~pre_lvl_ff;
                if (pre_cnt_ff >= pre_eff - `CDZ_ONE3) begin
                    pre_cnt_ff <= `CDZ_ZERO3;
                    pre_tick_ff <= 1'b1;
                end else begin
                    pre_cnt_ff <= pre_cnt_ff + `CDZ_ONE3;
                end
            end
        end
    end

    logic div_tick;
    logic src_pulse_d_ff;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            src_pulse_d_ff <= 1'b0;
        end else begin
            src_pulse_d_ff <= src_pulse;
        end
    end
    // bypass path uses raw input pulse, delayed to match pre-divider latency
    assign div_tick = (src_sel == `CDZ_SRC_EXT_BYP) ? src_pulse_d_ff : pre_tick_ff;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            src_illegal <= 1'b0;
        end else begin
            src_illegal <= (src_sel == `CDZ_SRC_FORBID) ||
                           ((|direct_route) && src_sel == `CDZ_SRC_EXT_BYP) ||
                           ((|div_bypass) && pre_eff == `CDZ_PRE_MIN);
        end
    end

    // ==========================================================
    // spacing of divider ticks in clock cycles, saturating
    logic [`CDZ_CNT_W-1:0] gap_cnt_ff;
    logic [`CDZ_CNT_W-1:0] gap_ff;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            gap_cnt_ff <= `CDZ_ZERO4;
            gap_ff <= `CDZ_ZERO4;
        end else if (div_tick) begin
            gap_cnt_ff <= `CDZ_ZERO4;
            gap_ff <= (gap_cnt_ff == '1) ? gap_cnt_ff : gap_cnt_ff + `CDZ_ONE4;
        end else if (gap_cnt_ff != '1) begin
            gap_cnt_ff <= gap_cnt_ff + `CDZ_ONE4;
        end
    end

    // ==========================================================
    // channel dividers, all sharing one tick and one sync
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            logic [`CDZ_CNT_W-1:0] m, n, d;
            logic [`CDZ_CNT_W-1:0] cnt_ff;
            logic [`CDZ_CNT_W-1:0] dly_ff;
            logic lvl_ff;
            logic [`CDZ_CNT_W-1:0] stretch_ff;
            logic out_ff;
            cdz_phase_t ph_ff;
            logic odd_dcc;
            assign m = low_cnt[g*`CDZ_CNT_W +: `CDZ_CNT_W];
            assign n = high_cnt[g*`CDZ_CNT_W +: `CDZ_CNT_W];
            assign d = phase_dly[g*`CDZ_CNT_W +: `CDZ_CNT_W];
            // n of all ones must not wrap into a match with m of zero
            assign odd_dcc = !dcc_disable[g] && (n != '1) && (m == n + `CDZ_ONE4);

            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    ph_ff <= CDZ_PH_HOLD;
                    cnt_ff <= `CDZ_ZERO4;
                    dly_ff <= `CDZ_ZERO4;
                    lvl_ff <= 1'b0;
                end else if (sync_req) begin
                    ph_ff <= CDZ_PH_HOLD;
                    cnt_ff <= `CDZ_ZERO4;
                    dly_ff <= `CDZ_ZERO4;
                    lvl_ff <= start_high[g];
                end else if (div_tick) begin
                    unique case (ph_ff)
                        CDZ_PH_HOLD: begin
                            lvl_ff <= start_high[g];
                            if (d == `CDZ_ZERO4) begin
                                ph_ff <= CDZ_PH_RUN;
                            end else begin
                                ph_ff <= CDZ_PH_DELAY;
                                dly_ff <= `CDZ_ONE4;
                            end
                        end
                        CDZ_PH_DELAY: begin
                            if (dly_ff >= d) begin
                                ph_ff <= CDZ_PH_RUN;
                            end else begin
                                dly_ff <= dly_ff + `CDZ_ONE4;
                            end
                        end
                        CDZ_PH_RUN: begin
                            if (cnt_ff >= (lvl_ff ? n : m)) begin
                                cnt_ff <= `CDZ_ZERO4;
                                lvl_ff <= ~lvl_ff;
                            end else begin
                                cnt_ff <= cnt_ff + `CDZ_ONE4;
                            end
                        end
                        default: ph_ff <= CDZ_PH_HOLD;
                    endcase
                end
            end

            // correction: hold the falling edge for half a tick spacing;
            // with one tick per clock the half tick rounds to nothing
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    stretch_ff <= `CDZ_ZERO4;
                end else if (sync_req) begin
                    stretch_ff <= `CDZ_ZERO4;
                end else if (div_tick && ph_ff == CDZ_PH_RUN && lvl_ff && cnt_ff >= n) begin
                    stretch_ff <= gap_ff >> 1;
                end else if (stretch_ff != `CDZ_ZERO4) begin
                    stretch_ff <= stretch_ff - `CDZ_ONE4;
                end
            end

            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    out_ff <= 1'b0;
                end else if (direct_route[g]) begin
                    out_ff <= pre_lvl_ff;
                end else if (div_bypass[g]) begin
                    out_ff <= pre_lvl_ff;
                end else if (odd_dcc) begin
                    out_ff <= lvl_ff | (stretch_ff != `CDZ_ZERO4);
                end else begin
                    out_ff <= lvl_ff;
                end
            end
            assign ch_lvl[g] = out_ff;
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            clock_output_pins <= '0;
        end else begin
            clock_output_pins <= ch_lvl;
        end
    end

    // ==========================================================
    // zero-delay feedback multiplexers
    logic feedback_source_mux;
    always_comb begin
        unique case (zd_mode)
            `CDZ_ZD_INTERNAL: feedback_source_mux = ch_lvl[0];
            `CDZ_ZD_EXTERNAL: feedback_source_mux = ext_clk_lvl;
            default: feedback_source_mux = ch_lvl[fb_div_sel];
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            loop_feedback_mux <= 1'b0;
        end else begin
            loop_feedback_mux <= feedback_source_mux;
        end
    end
endmodule : cdz_clock_distribution

// >>> test/cdz_chk_assertions.sv
`timescale 1ns/1ps
module cdz_chk #(
    parameter int NCH = 4
) (
    input wire logic ref_clk, // clock
    input wire logic resetn, // async reset
    input wire logic sync_req, // divider hold
    input wire logic ext_clk_lvl, // external level
    input wire logic [1:0] zd_mode, // zero-delay mode
    input wire logic [1:0] fb_div_sel, // feedback select
    input wire logic [1:0] src_sel, // source field
    input wire logic [2:0] pre_ratio, // pre-divider ratio
    input wire logic [NCH-1:0] div_bypass, // bypass bits
    input wire logic [NCH-1:0] direct_route, // direct bits
    input wire logic [NCH-1:0] clock_output_pins, // channel outputs
    input wire logic loop_feedback_mux, // feedback out
    input wire logic src_illegal // illegal flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    wire logic bad = src_sel == 2'h3 || (|direct_route && src_sel == 2'h1) || (|div_bypass && pre_ratio <= 3'h1);
    logic seen_edge_ff = 1'b0;
    always @(posedge ref_clk) seen_edge_ff <= 1'b1;
    chk_src_forbid: assert property ((src_sel == 2'h3) [*3] |-> src_illegal) else $error("forbidden source");
    chk_direct_src: assert property ((|direct_route && src_sel == 2'h1) [*3] |-> src_illegal)
        else $error("direct route without pre-divider");
    chk_bypass_pre: assert property ((|div_bypass && pre_ratio == 3'h1) [*3] |-> src_illegal)
        else $error("bypass with ratio one");
    chk_legal_clear: assert property ((!bad) [*3] |-> !src_illegal) else $error("spurious illegal flag");
    chk_fb_internal: assert property ((zd_mode == 2'h1) [*4] |-> loop_feedback_mux == clock_output_pins[0] ||
        loop_feedback_mux == $past(clock_output_pins[0])) else $error("internal feedback not channel zero");
    chk_fb_external: assert property ((zd_mode == 2'h3) [*4] |-> loop_feedback_mux == $past(ext_clk_lvl) ||
        loop_feedback_mux == $past(ext_clk_lvl, 2)) else $error("external feedback not clock input");
    chk_fb_select: assert property (!$past(zd_mode[0]) |-> loop_feedback_mux == clock_output_pins[$past(fb_div_sel)])
        else $error("feedback not selected channel");
    chk_sync_hold: assert property ((sync_req && direct_route == '0 && div_bypass == '0) [*5]
        |-> $stable(clock_output_pins)) else $error("outputs move while held");
    chk_reset_zero: assert property (disable iff (1'b0) !resetn && seen_edge_ff |-> clock_output_pins == '0 && !src_illegal)
        else $error("outputs not cleared in reset");
endmodule : cdz_chk
bind cdz_clock_distribution cdz_chk #(.NCH(NCH)) u_chk (.ref_clk, .resetn, .sync_req, .ext_clk_lvl, .zd_mode, .fb_div_sel,
    .src_sel, .pre_ratio, .div_bypass, .direct_route, .clock_output_pins, .loop_feedback_mux, .src_illegal);

// >>> test/cdz_source_model.sv
`timescale 1ns/1ps
module cdz_source_model (
    input wire logic ref_clk, // bench clock
    input wire logic slow, // pulse every other cycle
    input wire logic fb_pin, // looped-back channel output
    output logic osc_clk_en, // oscillator cycle marker
    output logic ext_clk_en, // external cycle marker
    output logic ext_clk_lvl // external input level
);
    logic ph_ff = 1'b1;
    always_ff @(negedge ref_clk) ph_ff <= slow ? ~ph_ff : 1'b1;
    assign osc_clk_en = ph_ff;
    assign ext_clk_en = ph_ff;
    assign ext_clk_lvl = fb_pin;
endmodule : cdz_source_model

// >>> test/tb_cdz_clock_distribution.sv
`timescale 1ns/1ps
module tb_cdz_clock_distribution;
    logic ref_clk = 1'b0, resetn = 1'b0, sync_req = 1'b0, slow = 1'b0;
    logic osc_clk_en, ext_clk_en, ext_clk_lvl, loop_feedback_mux, src_illegal;
    logic [1:0] zd_mode = 2'h0, fb_div_sel = 2'h0, src_sel = 2'h2;
    logic [2:0] pre_ratio = 3'h1;
    logic [15:0] low_cnt = 16'h0, high_cnt = 16'h0, phase_dly = 16'h0;
    logic [3:0] div_bypass = 4'h0, dcc_disable = 4'hf, start_high = 4'h0, direct_route = 4'h0, clock_output_pins;
    int n_errors = 0, cmp_count = 0, seed = 32'h3497bd56, i, hi, lo, n, m, p, d, s, t0r, t0f, t1;
    int tsrc[5] = '{3, 1, 0, 0, 2}, tbyp[5] = '{0, 0, 1, 1, 0}, tpre[5] = '{3, 3, 1, 2, 1};
    int tdr[5] = '{0, 1, 0, 0, 1}, tex[5] = '{1, 1, 1, 0, 0};
    initial forever #50 ref_clk = ~ref_clk;
    cdz_source_model src_m (.ref_clk, .slow, .fb_pin(clock_output_pins[0]), .osc_clk_en, .ext_clk_en, .ext_clk_lvl);
    cdz_clock_distribution #(.NCH(4)) dut (.ref_clk, .resetn, .osc_clk_en, .ext_clk_en, .ext_clk_lvl, .sync_req,
        .zd_mode, .fb_div_sel, .src_sel, .pre_ratio, .low_cnt, .high_cnt, .div_bypass, .dcc_disable, .phase_dly,
        .start_high, .direct_route, .clock_output_pins, .loop_feedback_mux, .src_illegal);
    task stop_test;
        if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    // counts cycles until the channel shows level v
    task wait_lvl(input int ch, input logic v, output int k);
        k = 0;
        while (clock_output_pins[ch] !== v) begin
            @(negedge ref_clk);
            k++;
            if (k > 999) begin
                n_errors++;
                stop_test();
            end
        end
    endtask : wait_lvl
    function int ticks(input int c, input int pr);
        return (c + 1) * pr * (slow ? 2 : 1);
    endfunction : ticks
    task resync;
        sync_req = 1'b1;
        repeat (6) @(negedge ref_clk);
        sync_req = 1'b0;
    endtask : resync
    initial begin
        repeat (12) @(negedge ref_clk);
        resetn = 1'b1;
        for (i = 0; i < 12; i++) begin
            n = i < 2 ? 15 * (1 - i) : $unsigned($random(seed)) % 16;
            m = i < 2 ? n : $unsigned($random(seed)) % 16;
            p = i < 2 ? 6 - 5 * i : 1 + $unsigned($random(seed)) % 6;
            src_sel = i < 2 ? 2'h2 : 2'($unsigned($random(seed)) % 3);
            pre_ratio = 3'(p);
            slow = i[0];
            zd_mode = 2'($random(seed));
            fb_div_sel = 2'($random(seed));
            d = $unsigned($random(seed)) % 4;
            high_cnt[d*4+:4] = 4'(n);
            low_cnt[d*4+:4] = 4'(m);
            resync();
            wait_lvl(d, 0, hi); wait_lvl(d, 1, hi); wait_lvl(d, 0, hi); wait_lvl(d, 1, lo);
            check("high time", 16'(hi), 16'(ticks(n, src_sel == 2'h1 ? 1 : p)));
            check("low time", 16'(lo), 16'(ticks(m, src_sel == 2'h1 ? 1 : p)));
        end
        {slow, src_sel, pre_ratio, high_cnt, low_cnt} = {1'b0, 2'h2, 3'h1, 16'h7777, 16'h7777};
        for (i = 0; i < 3; i++) begin
            d = 2 + $unsigned($random(seed)) % 14;
            s = $random(seed) & 1;
            phase_dly = 16'(d << 4);
            start_high = 4'(s << 1);
            resync();
            {t0r, t0f, t1} = '0;
            for (n = 1; n < 200; n++) begin
                @(negedge ref_clk);
                if (t0r == 0 && clock_output_pins[0] === 1'b1) begin
                    t0r = n;
                    check("delayed level", 16'(clock_output_pins[1]), 16'(s));
                end
                if (t0r != 0 && t0f == 0 && clock_output_pins[0] === 1'b0) t0f = n;
                if (t1 == 0 && clock_output_pins[1] !== 1'(s)) t1 = n;
            end
            check("phase offset", 16'(t1 - t0r), 16'(d));
            check("channel zero high", 16'(t0f - t0r), 16'(ticks(7, 1)));
        end
        {phase_dly, start_high, dcc_disable, high_cnt, low_cnt, pre_ratio} = {16'h0, 4'h0, 4'h0, 16'h2, 16'h3, 3'h2};
        resync();
        wait_lvl(0, 0, hi); wait_lvl(0, 1, hi); wait_lvl(0, 0, hi); wait_lvl(0, 1, lo);
        check("corrected period", 16'(hi + lo), 16'(ticks(2, 2) + ticks(3, 2)));
        check("corrected high", 16'(hi), 16'((ticks(2, 2) + ticks(3, 2)) / 2));
        for (i = 0; i < 5; i++) begin
            {src_sel, div_bypass, pre_ratio, direct_route} = {2'(tsrc[i]), 4'(tbyp[i]), 3'(tpre[i]), 4'(tdr[i] << 3)};
            repeat (5) @(negedge ref_clk);
            check("illegal flag", 16'(src_illegal), 16'(tex[i]));
        end
        wait_lvl(3, 0, hi); wait_lvl(3, 1, hi); wait_lvl(3, 0, hi);
        check("direct high time", 16'(hi), 16'h1);
        stop_test();
    end
endmodule : tb_cdz_clock_distribution
